// ===== cpu_extended_opcode_timing_tb.sv
module cpu_extended_opcode_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [15:0] maddr = 16'h0;
  reg [31:0] rv = 32'h0;
  reg [31:0] lfsr = 32'h00012629;
  wire [15:0] mword;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire busy_q;
  wire mem_rd_q;
  wire mem_wr_q;
  integer num_errors = 0;
  integer total_checks = 0;
  integer bcnt = 0;
  integer bst = 0;
  integer i;
  ext_opcode_timing ext_opcode_timing_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .busy_q(busy_q), .mem_rd_q(mem_rd_q), .mem_wr_q(mem_wr_q));
  mem_model mem_model_i (.addr(maddr), .word(mword));
  // Clock at 125 MHz
  always #4 hclk = ~hclk;
  // Instruction length measured on the busy line
  always @(posedge hclk) if (busy_q) bcnt <= bcnt + 1;
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] arith_shift_right_op(input [7:0] a);
    arith_shift_right_op = {a[7], a[7:1]};
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // One single transfer; waits on hready, read data taken at the data edge
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rv = hrdata;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Idle first; a read right after a write to it would still see the new value
  task rd(input [7:0] a);
    begin
      @(posedge hclk);
      bus(1'b0, a, 32'h0);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] exp);
    begin
      rd(a);
      check(rv, exp);
    end
  endtask
  // Issue one opcode, poll until idle, compare length and size
  task ex(input [7:0] op, input [31:0] opd, input [31:0] mem, input [31:0] cnd,
          input [31:0] cyc, input [7:0] byt);
    begin
      wr(8'h04, opd);
      wr(8'h08, mem);
      wr(8'h0C, cnd);
      bst = bcnt;
      wr(8'h00, {24'h0, op});
      rv = 32'h1;
      while (rv[0] !== 1'b0) rd(8'h10);
      check(bcnt - bst, cyc);
      check(rv[19:12], byt);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Watchdog well beyond the expected run of about 800 cycles
  initial begin
    #200000;
    num_errors = num_errors + 1;
    conclude;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(8'h1C, 32'h0);
    ex(8'h87, 32'h05, 32'h40, 0, 5, 2);
    ex(8'h77, 32'h05, 32'h80, 0, 5, 2);
    ex(8'h8F, 32'h0305, 32'h01, 0, 6, 3);
    // Far page taken: next opcode at 00F3, target 0172
    wr(8'h1C, 32'h000000F0);
    ex(8'h8F, 32'h7F05, 32'h01, 0, 7, 3);
    ex(8'h0F, 32'h0305, 32'h01, 0, 5, 3);
    ex(8'hF2, 32'h01010101, 32'hFF, 0, 8, 5);
    ex(8'hE2, 32'h01010101, 32'hFF, 0, 7, 5);
    ex(8'hD2, 32'h0F0200, 32'h0, 0, 7, 4);
    ex(8'hC2, 32'h0F0200, 32'hFF, 0, 7, 4);
    ex(8'hB2, 32'h5510, 0, 0, 4, 3);
    ex(8'h02, 0, 0, 0, 6, 1);
    ex(8'h12, 0, 0, 0, 6, 1);
    ex(8'hD4, 32'h10, 32'h3C, 0, 5, 2);
    // W and V preloaded so the clear is visible
    wr(8'h18, 32'h0000BEEF);
    wr(8'h1C, 32'h00080000);
    ex(8'h52, 0, 0, 0, 2, 1);
    rd(8'h18);
    check(rv[15:0], 16'h0);
    rd(8'h1C);
    check(rv[19], 1'b0);
    ex(8'h6C, 32'h12FF, 0, 0, 5, 3);
    rdc(8'h20, 32'h130012FF);
    // Random accumulator values, first with the sign bit forced
    for (i = 0; i < 4; i = i + 1) begin
      lfsr = nxt(lfsr);
      if (i == 0) lfsr[7] = 1'b1;
      wr(8'h14, {8'hFF, 16'h0, lfsr[7:0]});
      ex(8'h42, 0, 0, 0, 2, 1);
      rdc(8'h14, {8'hFF, 16'h0, arith_shift_right_op(lfsr[7:0])});
    end
    for (i = 0; i < 8; i = i + 1) begin
      ex({i[3:0], 4'hB}, 0, 32'h1234, 0, 6, 1);
      rd(8'h20);
      check(rv[15:0], 16'hFFE0 + {i[14:0], 1'b0});
    end
    ex(8'h22, 0, 0, 0, 5, 1);
    ex(8'h32, 0, 32'h00C3B2A1, 0, 6, 1);
    rdc(8'h14, 32'hEFA1B2C3);
    // Threaded code from a random pointer
    lfsr = nxt(lfsr);
    maddr <= lfsr[15:0];
    wr(8'h18, {lfsr[15:0], 16'h0});
    ex(8'hAB, 0, {16'h0, mword}, 0, 3, 1);
    rdc(8'h18, {lfsr[15:0] + 16'h1, 16'h0});
    wr(8'h1C, {16'h0, lfsr[31:16]});
    ex(8'h8B, 0, {16'h0, mword}, 0, 5, 3);
    rd(8'h18);
    check(rv[31:16], {lfsr[31:16] + 16'h3});
    ex(8'hBB, 0, 0, 0, 2, 1);
    rd(8'h1C);
    check(rv[15:0], {lfsr[31:16] + 16'h3});
    ex(8'h9B, 0, {16'h0, mword}, 0, 5, 1);
    rd(8'h18);
    check(rv[31:16], mword);
    wr(8'h1C, {16'h0, lfsr[15:0]});
    ex(8'h20, 0, 0, 0, 5, 3);
    rd(8'h24);
    check(rv[15:0], {lfsr[15:0] + 16'h3});
    ex(8'h60, 0, {16'h0, mword}, 0, 5, 1);
    rd(8'h1C);
    check(rv[15:0], mword);
    // Decimal add 99 + 01 wraps to 00 with carry
    wr(8'h14, 32'hFF000099);
    wr(8'h1C, 32'h00040000);
    ex(8'h69, 32'h01, 0, 32'h2820, 3, 2);
    rd(8'h14);
    check(rv[7:0], 8'h00);
    rd(8'h1C);
    check(rv[20:16], 5'h07);
    wr(8'h1C, 32'h0);
    ex(8'h69, 32'h01, 0, 32'h2820, 2, 2);
    ex(8'hD0, 32'h10, 0, 32'h2221, 3, 2);
    ex(8'hD0, 32'h10, 0, 32'h2223, 4, 2);
    ex(8'hBD, 32'h1234, 0, 32'h3144, 5, 3);
    ex(8'h00, 0, 0, 32'h1078, 14, 1);
    conclude;
  end
endmodule // cpu_extended_opcode_timing_tb

// ===== ext_opcode_checker_assertions.sv
module ext_opcode_checker (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus request
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  // Bus answer
  input wire hreadyout,
  input wire hresp,
  // Execution state
  input wire busy_q,
  input wire mem_rd_q,
  input wire mem_wr_q
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Opcode write accepted while idle
  sequence issue;
    hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00 && !busy_q;
  endsequence
  // Read-modify-write fetch steps
  sequence two_reads;
    mem_rd_q [*2];
  endsequence
  chk_zero_wait: assert property (hreadyout)
    else $error("wait state on bus");
  chk_okay_only: assert property (!hresp)
    else $error("error response");
  chk_issue_start: assert property (issue |-> ##1 !busy_q ##1 busy_q && mem_rd_q)
    else $error("opcode did not start at the data phase edge");
  chk_busy_bound: assert property (busy_q |-> ##[1:14] !busy_q)
    else $error("instruction ran too long");
  chk_rd_wr_excl: assert property (!(mem_rd_q && mem_wr_q))
    else $error("read and write in one cycle");
  chk_access_busy: assert property ((mem_rd_q || mem_wr_q) |-> busy_q)
    else $error("memory cycle while idle");
  chk_one_write: assert property (two_reads ##1 mem_wr_q |=> !mem_wr_q)
    else $error("double write");
  chk_reads_first: assert property (mem_wr_q |-> $past(mem_rd_q) && $past(mem_rd_q, 2))
    else $error("write not preceded by two reads");
endmodule // ext_opcode_checker

bind ext_opcode_timing ext_opcode_checker ext_opcode_checker_i (.hclk, .hresetn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .busy_q, .mem_rd_q, .mem_wr_q);

// ===== ext_opcode_regs.vh
`ifndef EXT_OPCODE_REGS_VH
`define EXT_OPCODE_REGS_VH
// Operation
// - Bit set and bit clear on a zero-page byte: two bytes, five cycles.
// - Zero-page bit test branches: three bytes, five to seven cycles by outcome.
// - Absolute mask test branches, all set or all clear: five bytes, seven to nine.
// - Absolute mask set and mask clear: four bytes, seven cycles.
// - Store immediate to zero page: three bytes, four cycles.
// - Signed multiply into A,Y; multiply-accumulate into W; one byte, six cycles.
// - Arithmetic right shift of A keeps the sign bit; one byte, two cycles.
// - Swap A with zero-page byte indexed by X: two bytes, five cycles.
// - Eight one-byte vectored calls fetch target from top vector table, six cycles.
// - Push A,X,Y in five cycles; pull Y,X,A in six cycles.
// - Load A from thread pointer address, then advance pointer by one, three cycles.
// - Thread jump: I gets PC+1, jump through operand, I advances two; 3 bytes, 5 cycles.
// - Thread return copies I into PC; one byte, two cycles.
// - Thread reload replaces I with the word it points at, five cycles.
// - Indirect jump operand at page end carries into page for high byte.
// - Read-modify-write does two reads then one write, never two writes.
// - Reset clears the decimal flag.
// - Decimal add or subtract takes one cycle more than binary.
// - Decimal add or subtract sets N, V, Z from the corrected result.
// - Interrupt coincident with break is serviced first, then break executes.
// - Call pushes next opcode address, return uses it as is, both one cycle shorter.
// - Word clear zeroes W and V; one byte, two cycles.
// - Taken branch adds one cycle same page, two cycles other page.
// - Indexed access crossing a page adds one cycle.

// Register byte offsets
`define OFS_OPCODE 8'h00
`define OFS_OPERAND 8'h04
`define OFS_MEMDATA 8'h08
`define OFS_COND 8'h0C
`define OFS_STATUS 8'h10
`define OFS_REGS 8'h14
`define OFS_WORDS 8'h18
`define OFS_PCFLAGS 8'h1C
`define OFS_VECTOR 8'h20
`define OFS_RESULT 8'h24

// Condition register fields
`define COND_TAKEN 0
`define COND_FAR 1
`define COND_XCROSS 2
`define COND_IRQ 3
`define COND_BASE_LO 4
`define COND_BASE_HI 7
`define COND_BIDX 8
`define COND_BBR 9
`define COND_BRMW 10
`define COND_BARITH 11
`define COND_BYTES_LO 12
`define COND_BYTES_HI 13

// Reset values
`define RST_SP 8'hFF
`define RST_PC 16'h0000

// Opcodes of the extended set (families use the low nibble)
`define OP_BRK 8'h00
`define OP_JSR 8'h20
`define OP_RTS 8'h60
`define OP_JMP_IND 8'h6C
`define OP_ADC_IMM 8'h69
`define OP_SBC_IMM 8'hE9
`define NIB_BIT_ZP 4'h7
`define NIB_BRANCH_BIT 4'hF
`define NIB_CALL 4'hB
`define OP_THREAD_JUMP 8'h8B
`define OP_THREAD_RELOAD 8'h9B
`define OP_LOAD_ADVANCE 8'hAB
`define OP_THREAD_RETURN 8'hBB
`define OP_STORE_IMM 8'hB2
`define OP_MASK_CLEAR 8'hC2
`define OP_MASK_SET 8'hD2
`define OP_BRANCH_ZERO 8'hE2
`define OP_BRANCH_SET 8'hF2
`define OP_SWAP 8'hD4
`define OP_MULTIPLY 8'h02
`define OP_MULT_ACC 8'h12
`define OP_ASR 8'h42
`define OP_WORD_CLEAR 8'h52
`define OP_PUSH3 8'h22
`define OP_PULL3 8'h32

// Cycle counts
`define CYC_BIT_ZP 5'd5
`define CYC_BRANCH_BIT 5'd5
`define CYC_BRANCH_MASK 5'd7
`define CYC_MASK_RMW 5'd7
`define CYC_STORE_IMM 5'd4
`define CYC_MULT 5'd6
`define CYC_SHORT 5'd2
`define CYC_SWAP 5'd5
`define CYC_CALL 5'd6
`define CYC_PUSH3 5'd5
`define CYC_PULL3 5'd6
`define CYC_LOAD_ADV 5'd3
`define CYC_THREAD_JUMP 5'd5
`define CYC_THREAD_RELOAD 5'd5
`define CYC_ORIG_CALL 5'd6
`define CYC_ORIG_RETURN 5'd6
`define CYC_JMP_IND 5'd5
`define CYC_BREAK 5'd7
`define VEC_CALL_BASE 16'hFFE0
`define VEC_BREAK 16'hFFFE
`endif

// ===== ext_opcode_timing.v
`include "ext_opcode_regs.vh"

module ext_opcode_timing (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Execution state
  output reg busy_q,
  output reg mem_rd_q,
  output reg mem_wr_q
);

  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_IRQ = 2'd2;

  reg [1:0] state_q;
  reg [4:0] cnt_q;
  reg [4:0] total_q;
  reg [7:0] op_q;
  reg brk_pend_q;
  reg rmw_q;
  reg wr_last_q;
  reg [31:0] opnd_q;
  reg [31:0] mem_q;
  reg [13:0] cond_q;
  reg [7:0] a_q, x_q, y_q, sp_q;
  reg [15:0] w_q, i_q, pc_q;
  reg n_q, v_q, d_q, c_q, z_q;
  reg [15:0] vec_lo_q, vec_hi_q;
  reg [15:0] wr_addr_q;
  reg [7:0] wr_data_q;
  reg [7:0] last_bytes_q;
  reg [4:0] last_cyc_q;
  reg wr_pend_q;
  reg [7:0] wr_ofs_q;

  // BCD add of two digits-pairs with carry in; returns {carry, sum}
  function [8:0] bcd_add;
    input [7:0] a;
    input [7:0] b;
    input ci;
    reg [4:0] lo;
    reg [4:0] hi;
    begin
      lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      if (lo > 5'd9)
        lo = lo + 5'd6;
      hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
      if (hi > 5'd9)
        hi = hi + 5'd6;
      bcd_add = {hi[4], hi[3:0], lo[3:0]};
    end
  endfunction

  // Relative branch target from the address after the instruction
  function [15:0] rel_target;
    input [15:0] next_pc;
    input [7:0] rel;
    begin
      rel_target = next_pc + {{8{rel[7]}}, rel};
    end
  endfunction

  // Branch penalty: one cycle same page, two across pages
  function [4:0] br_extra;
    input taken;
    input far;
    begin
      br_extra = taken ? (far ? 5'd2 : 5'd1) : 5'd0;
    end
  endfunction

  // Decode of issued opcode
  wire [7:0] opw = hwdata[7:0];
  wire is_bit_zp = (opw[3:0] == `NIB_BIT_ZP);
  wire is_br_bit = (opw[3:0] == `NIB_BRANCH_BIT);
  wire is_call = (opw[3:0] == `NIB_CALL) && !opw[7];
  wire is_br_mask = (opw == `OP_BRANCH_SET) || (opw == `OP_BRANCH_ZERO);
  wire is_arith = (opw == `OP_ADC_IMM) || (opw == `OP_SBC_IMM);

  // Branch outcomes are worked out from the fetched data, not from software
  wire [15:0] bb_next = pc_q + 16'h0003;
  wire [15:0] bb_tgt = rel_target(bb_next, opnd_q[15:8]);
  wire bb_taken = (mem_q[opw[6:4]] == opw[7]);
  wire bb_far = (bb_tgt[15:8] != bb_next[15:8]);
  wire [15:0] bm_next = pc_q + 16'h0005;
  wire [15:0] bm_tgt = rel_target(bm_next, opnd_q[31:24]);
  wire [7:0] bm_and = mem_q[7:0] & opnd_q[23:16];
  wire bm_taken = (opw == `OP_BRANCH_SET) ? (bm_and == opnd_q[23:16]) : (bm_and == 8'h00);
  wire bm_far = (bm_tgt[15:8] != bm_next[15:8]);

  // Cycle count of the opcode on hwdata
  reg [4:0] cyc_d;
  reg [2:0] bytes_d;
  reg rmw_d;
  reg wrl_d;
  always @* begin
    cyc_d = cond_q[`COND_BASE_HI:`COND_BASE_LO] + {4'h0, cond_q[`COND_BIDX] &
      cond_q[`COND_XCROSS]};
    if (cond_q[`COND_BBR])
      cyc_d = cyc_d + br_extra(cond_q[`COND_TAKEN], cond_q[`COND_FAR]);
    if (cond_q[`COND_BARITH])
      cyc_d = cyc_d + {4'h0, d_q};
    bytes_d = {1'b0, cond_q[`COND_BYTES_HI:`COND_BYTES_LO]};
    rmw_d = cond_q[`COND_BRMW];
    wrl_d = 1'b0;
    if (is_bit_zp) begin
      cyc_d = `CYC_BIT_ZP;
      bytes_d = 3'd2;
      rmw_d = 1'b1;
    end else if (is_br_bit) begin
      cyc_d = `CYC_BRANCH_BIT + br_extra(bb_taken, bb_far);
      bytes_d = 3'd3;
      rmw_d = 1'b0;
    end else if (is_call) begin
      cyc_d = `CYC_CALL;
      bytes_d = 3'd1;
      rmw_d = 1'b0;
    end else if (is_br_mask) begin
      cyc_d = `CYC_BRANCH_MASK + br_extra(bm_taken, bm_far);
      bytes_d = 3'd5;
      rmw_d = 1'b0;
    end else if (is_arith) begin
      cyc_d = `CYC_SHORT + {4'h0, d_q};
      bytes_d = 3'd2;
      rmw_d = 1'b0;
    end else begin
      case (opw)
        `OP_MASK_SET, `OP_MASK_CLEAR: begin
          cyc_d = `CYC_MASK_RMW;
          bytes_d = 3'd4;
          rmw_d = 1'b1;
        end
        `OP_STORE_IMM: begin
          cyc_d = `CYC_STORE_IMM;
          bytes_d = 3'd3;
          rmw_d = 1'b0;
          wrl_d = 1'b1;
        end
        `OP_MULTIPLY, `OP_MULT_ACC: begin
          cyc_d = `CYC_MULT;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
        end
        `OP_ASR, `OP_WORD_CLEAR, `OP_THREAD_RETURN: begin
          cyc_d = `CYC_SHORT;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
        end
        `OP_SWAP: begin
          cyc_d = `CYC_SWAP;
          bytes_d = 3'd2;
          rmw_d = 1'b1;
        end
        `OP_PUSH3: begin
          cyc_d = `CYC_PUSH3;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
          wrl_d = 1'b1;
        end
        `OP_PULL3: begin
          cyc_d = `CYC_PULL3;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
        end
        `OP_LOAD_ADVANCE: begin
          cyc_d = `CYC_LOAD_ADV;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
        end
        `OP_THREAD_JUMP: begin
          cyc_d = `CYC_THREAD_JUMP;
          bytes_d = 3'd3;
          rmw_d = 1'b0;
        end
        `OP_THREAD_RELOAD: begin
          cyc_d = `CYC_THREAD_RELOAD;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
        end
        `OP_JSR: begin
          cyc_d = `CYC_ORIG_CALL - 5'd1;
          bytes_d = 3'd3;
          rmw_d = 1'b0;
          wrl_d = 1'b1;
        end
        `OP_RTS: begin
          cyc_d = `CYC_ORIG_RETURN - 5'd1;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
        end
        `OP_JMP_IND: begin
          cyc_d = `CYC_JMP_IND;
          bytes_d = 3'd3;
          rmw_d = 1'b0;
        end
        `OP_BRK: begin
          cyc_d = `CYC_BREAK;
          bytes_d = 3'd1;
          rmw_d = 1'b0;
          wrl_d = 1'b1;
        end
        default: begin
          cyc_d = cyc_d;
        end
      endcase
    end
    if (cyc_d == 5'd0)
      cyc_d = 5'd1;
  end

  // AHB address phase capture; zero wait states
  wire ahb_go = hsel && htrans[1] && hready;
  wire busy_now = (state_q != ST_IDLE);
  reg [31:0] rd_mux;
  always @* begin
    case (haddr[7:0])
      `OFS_OPERAND: rd_mux = opnd_q;
      `OFS_MEMDATA: rd_mux = mem_q;
      `OFS_COND: rd_mux = {18'h0, cond_q};
      `OFS_STATUS: rd_mux = {7'h00, last_cyc_q, last_bytes_q, 3'h0, total_q,
        brk_pend_q, state_q, busy_now};
      `OFS_REGS: rd_mux = {sp_q, y_q, x_q, a_q};
      `OFS_WORDS: rd_mux = {i_q, w_q};
      `OFS_PCFLAGS: rd_mux = {11'h0, n_q, v_q, d_q, c_q, z_q, pc_q};
      `OFS_VECTOR: rd_mux = {vec_hi_q, vec_lo_q};
      `OFS_RESULT: rd_mux = {8'h0, wr_data_q, wr_addr_q};
      `OFS_OPCODE: rd_mux = {24'h0, op_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= ahb_go && hwrite;
      if (ahb_go) begin
        wr_ofs_q <= haddr[7:0];
        if (!hwrite)
          hrdata <= rd_mux;
      end
    end
  end

  // Data-phase writes; opcode and state writes are ignored while executing
  wire wr_op = wr_pend_q && (wr_ofs_q == `OFS_OPCODE) && !busy_now;
  wire wr_st = wr_pend_q && !busy_now;

  // Product and decimal arithmetic for the result commit
  wire signed [15:0] prod = $signed(a_q) * $signed(y_q);
  wire [7:0] arith_b = (op_q == `OP_SBC_IMM) ? (8'h99 - opnd_q[7:0]) : opnd_q[7:0];
  wire [7:0] arith_bb = (op_q == `OP_SBC_IMM) ? ~opnd_q[7:0] : opnd_q[7:0];
  wire [8:0] dec_sum = bcd_add(a_q, arith_b, c_q);
  wire [8:0] bin_sum = {1'b0, a_q} + {1'b0, arith_bb} + {8'h00, c_q};
  wire [8:0] add_res = d_q ? dec_sum : bin_sum;
  wire [7:0] swap_addr = opnd_q[7:0] + x_q;
  wire [7:0] bit_mask = 8'h01 << op_q[6:4];
  wire last = (cnt_q == total_q);

  // Sequencer: count the cycles, classify bus cycles, commit at the end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'd0;
      total_q <= 5'd0;
      op_q <= 8'h00;
      brk_pend_q <= 1'b0;
      rmw_q <= 1'b0;
      wr_last_q <= 1'b0;
      opnd_q <= 32'h0000_0000;
      mem_q <= 32'h0000_0000;
      cond_q <= 14'h0000;
      a_q <= 8'h00;
      x_q <= 8'h00;
      y_q <= 8'h00;
      sp_q <= `RST_SP;
      w_q <= 16'h0000;
      i_q <= 16'h0000;
      pc_q <= `RST_PC;
      n_q <= 1'b0;
      v_q <= 1'b0;
      d_q <= 1'b0;
      c_q <= 1'b0;
      z_q <= 1'b0;
      vec_lo_q <= 16'h0000;
      vec_hi_q <= 16'h0000;
      wr_addr_q <= 16'h0000;
      wr_data_q <= 8'h00;
      last_bytes_q <= 8'h00;
      last_cyc_q <= 5'd0;
      busy_q <= 1'b0;
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
    end else begin
      if (wr_st && wr_ofs_q == `OFS_OPERAND)
        opnd_q <= hwdata;
      if (wr_st && wr_ofs_q == `OFS_MEMDATA)
        mem_q <= hwdata;
      if (wr_st && wr_ofs_q == `OFS_COND)
        cond_q <= hwdata[13:0];
      if (wr_st && wr_ofs_q == `OFS_REGS) begin
        a_q <= hwdata[7:0];
        x_q <= hwdata[15:8];
        y_q <= hwdata[23:16];
        sp_q <= hwdata[31:24];
      end
      if (wr_st && wr_ofs_q == `OFS_WORDS) begin
        w_q <= hwdata[15:0];
        i_q <= hwdata[31:16];
      end
      if (wr_st && wr_ofs_q == `OFS_PCFLAGS) begin
        pc_q <= hwdata[15:0];
        {n_q, v_q, d_q, c_q, z_q} <= hwdata[20:16];
      end
      mem_rd_q <= 1'b0;
      mem_wr_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          busy_q <= 1'b0;
          if (wr_op) begin
            op_q <= opw;
            total_q <= cyc_d;
            rmw_q <= rmw_d;
            wr_last_q <= wrl_d;
            cnt_q <= 5'd1;
            busy_q <= 1'b1;
            mem_rd_q <= 1'b1;
            last_bytes_q <= {5'h00, bytes_d};
            last_cyc_q <= cyc_d;
            if (opw == `OP_BRK && cond_q[`COND_IRQ]) begin
              brk_pend_q <= 1'b1;
              total_q <= `CYC_BREAK;
              state_q <= ST_IRQ;
            end else begin
              state_q <= ST_EXEC;
            end
          end
        end
        ST_IRQ, ST_EXEC: begin
          cnt_q <= cnt_q + 5'd1;
          // Read-modify-write: reads, a second read, one final write
          mem_wr_q <= (rmw_q || wr_last_q) && (cnt_q + 5'd1 == total_q);
          mem_rd_q <= !((rmw_q || wr_last_q) && (cnt_q + 5'd1 == total_q)) && !last;
          if (last) begin
            mem_rd_q <= 1'b0;
            mem_wr_q <= 1'b0;
            if (state_q == ST_IRQ) begin
              // Interrupt taken first; break then runs in full
              sp_q <= sp_q - 8'd3;
              pc_q <= mem_q[31:16];
              cnt_q <= 5'd1;
              total_q <= `CYC_BREAK;
              wr_last_q <= 1'b1;
              brk_pend_q <= 1'b0;
              state_q <= ST_EXEC;
            end else begin
              state_q <= ST_IDLE;
              busy_q <= 1'b0;
              pc_q <= pc_q + {13'h0000, last_bytes_q[2:0]};
              if (op_q[3:0] == `NIB_BIT_ZP) begin
                wr_addr_q <= {8'h00, opnd_q[7:0]};
                wr_data_q <= op_q[7] ? (mem_q[7:0] | bit_mask) :
                  (mem_q[7:0] & ~bit_mask);
              end else if (op_q[3:0] == `NIB_BRANCH_BIT) begin
                if (mem_q[op_q[6:4]] == op_q[7])
                  pc_q <= bb_tgt;
              end else if (op_q[3:0] == `NIB_CALL && !op_q[7]) begin
                vec_lo_q <= `VEC_CALL_BASE + {12'h000, op_q[6:4], 1'b0};
                pc_q <= mem_q[15:0];
                sp_q <= sp_q - 8'd2;
                wr_addr_q <= pc_q + 16'h0001;
              end else begin
                case (op_q)
                  `OP_BRANCH_SET, `OP_BRANCH_ZERO: begin
                    if ((op_q == `OP_BRANCH_SET) ? (bm_and == opnd_q[23:16]) :
                        (bm_and == 8'h00))
                      pc_q <= bm_tgt;
                  end
                  `OP_MASK_SET, `OP_MASK_CLEAR: begin
                    wr_addr_q <= opnd_q[15:0];
                    wr_data_q <= (op_q == `OP_MASK_SET) ? (mem_q[7:0] | opnd_q[23:16]) :
                      (mem_q[7:0] & ~opnd_q[23:16]);
                  end
                  `OP_STORE_IMM: begin
                    wr_addr_q <= {8'h00, opnd_q[7:0]};
                    wr_data_q <= opnd_q[15:8];
                  end
                  `OP_MULTIPLY: begin
                    a_q <= prod[15:8];
                    y_q <= prod[7:0];
                  end
                  `OP_MULT_ACC: begin
                    w_q <= w_q + prod;
                  end
                  `OP_ASR: begin
                    a_q <= {a_q[7], a_q[7:1]};
                    c_q <= a_q[0];
                    n_q <= a_q[7];
                    z_q <= (a_q[7:1] == 7'h00) && !a_q[7];
                  end
                  `OP_WORD_CLEAR: begin
                    w_q <= 16'h0000;
                    v_q <= 1'b0;
                  end
                  `OP_SWAP: begin
                    a_q <= mem_q[7:0];
                    wr_addr_q <= {8'h00, swap_addr};
                    wr_data_q <= a_q;
                  end
                  `OP_PUSH3: begin
                    sp_q <= sp_q - 8'd3;
                    wr_addr_q <= {8'h01, sp_q - 8'd2};
                    wr_data_q <= y_q;
                  end
                  `OP_PULL3: begin
                    y_q <= mem_q[7:0];
                    x_q <= mem_q[15:8];
                    a_q <= mem_q[23:16];
                    sp_q <= sp_q + 8'd3;
                  end
                  `OP_LOAD_ADVANCE: begin
                    a_q <= mem_q[7:0];
                    i_q <= i_q + 16'h0001;
                  end
                  `OP_THREAD_JUMP: begin
                    vec_lo_q <= pc_q + 16'h0001;
                    i_q <= pc_q + 16'h0003;
                    pc_q <= mem_q[15:0];
                  end
                  `OP_THREAD_RETURN: begin
                    pc_q <= i_q;
                  end
                  `OP_THREAD_RELOAD: begin
                    vec_lo_q <= i_q;
                    i_q <= mem_q[15:0];
                  end
                  `OP_JSR: begin
                    wr_addr_q <= pc_q + 16'h0003;
                    sp_q <= sp_q - 8'd2;
                    pc_q <= opnd_q[15:0];
                  end
                  `OP_RTS: begin
                    pc_q <= mem_q[15:0];
                    sp_q <= sp_q + 8'd2;
                  end
                  `OP_JMP_IND: begin
                    vec_lo_q <= opnd_q[15:0];
                    vec_hi_q <= opnd_q[15:0] + 16'h0001;
                    pc_q <= mem_q[15:0];
                  end
                  `OP_ADC_IMM, `OP_SBC_IMM: begin
                    a_q <= add_res[7:0];
                    c_q <= add_res[8];
                    n_q <= add_res[7];
                    z_q <= (add_res[7:0] == 8'h00);
                    v_q <= (a_q[7] == arith_bb[7]) && (add_res[7] != a_q[7]);
                  end
                  `OP_BRK: begin
                    vec_lo_q <= `VEC_BREAK;
                    sp_q <= sp_q - 8'd3;
                    pc_q <= mem_q[15:0];
                  end
                  default: begin
                    pc_q <= pc_q + {13'h0000, last_bytes_q[2:0]};
                  end
                endcase
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ext_opcode_timing

// ===== mem_model.sv
module mem_model (
  // Address asked for
  input wire [15:0] addr,
  // Word stored there
  output wire [15:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Contents differ per address so a stale fetch shows up
  assign word = addr ^ 16'hA55A;
endmodule // mem_model
